// ---- hdl/optical_module_end.sv ----
// module end: laser control, fault latch, signal-loss pin and two-wire slave
//
// Behaviour
// - laser off within 10 us of pin rise
// - host spaces pin assertions at least 10 ms
// - laser back on within 2 ms of fall
// - power-on initialisation done within 300 ms
// - fault flag raised within 1 ms
// - pin high 10 us clears latched fault
// - signal-lost pin set within 100 us
// - signal-lost pin cleared within 100 us
// - soft-off bit acts within 100 ms of stop
// - fault status bit set within 100 ms
// - signal-lost status bit follows within 100 ms
// - data-ready bit within 1000 ms of power-on
// - both bus addresses answer within 300 ms
// - write cycle 40 ms or 80 ms
// - host bus clock at most 400 kHz
// - module may stretch clock, host waits
// - host idles bus 20 us after stop
`timescale 1ns/10ps
`include "optical_defs.svh"
module optical_module_end
  import optical_pkg::*;
#(
  parameter int unsigned INIT_CYC = `T_INIT_CYC,
  parameter int unsigned RESET_CYC = `T_RESET_CYC,
  parameter int unsigned WR4_CYC = `T_WR4_CYC,
  parameter int unsigned WR8_CYC = `T_WR8_CYC,
  parameter int unsigned STRETCH_CYC = `STRETCH_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  optical_link_if.module_end link,
  input wire logic laser_fault_in,
  input wire logic signal_present_in,
  input wire logic analog_ok_in,
  output logic laser_on,
  output logic link_ready
);
  if (INIT_CYC < 1 || RESET_CYC < 1 || WR4_CYC < 1 || WR8_CYC < WR4_CYC || STRETCH_CYC > 255) begin : g_bad
    $error("optical_module_end timing parameters out of range");
  end

  // ----------------------------------------
  // input sampling
  // ----------------------------------------
  logic [5:0] s;
  logic scl_q;
  logic sda_q;
  sync2 #(.WIDTH(6)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din({link.laser_off_request, ~link.scl, ~link.sda, laser_fault_in, signal_present_in, analog_ok_in}),
    .dout(s)
  );
  wire dis = s[5];
  wire scl_r = ~s[4]; // inverted: idle high after reset
  wire sda_r = ~s[3];
  wire fault_s = s[2];
  wire sig_s = s[1];
  wire ana_s = s[0];
  wire scl_rise = scl_r & ~scl_q;
  wire scl_fall = ~scl_r & scl_q;
  wire start_cond = scl_r & scl_q & sda_q & ~sda_r;
  wire stop_cond = scl_r & scl_q & ~sda_q & sda_r;
  // previous levels for edge detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_r;
      sda_q <= sda_r;
    end
  end

  // ----------------------------------------
  // initialisation, laser and fault
  // ----------------------------------------
  logic [31:0] init_cnt;
  logic [31:0] dis_cnt;
  logic fault_latched;
  logic soft_off;
  logic los;
  logic data_ready;
  wire fault_clear = dis & (dis_cnt >= RESET_CYC - 1);
  // power-on timer gates laser and bus
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      init_cnt <= '0;
      link_ready <= 1'b0;
    end else if (init_cnt != INIT_CYC - 1) begin
      init_cnt <= init_cnt + 32'h0000_0001;
    end else begin
      link_ready <= 1'b1;
    end
  end
  // counts how long the disable pin has been high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dis_cnt <= '0;
    end else if (!dis) begin
      dis_cnt <= '0;
    end else if (dis_cnt != RESET_CYC) begin
      dis_cnt <= dis_cnt + 32'h0000_0001;
    end
  end
  // fault latch: a new fault wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fault_latched <= 1'b0;
    end else if (fault_s) begin
      fault_latched <= 1'b1;
    end else if (fault_clear) begin
      fault_latched <= 1'b0;
    end
  end
  // laser drive and status levels
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      laser_on <= 1'b0;
      los <= 1'b1;
      data_ready <= 1'b0;
    end else begin
      laser_on <= link_ready & ~dis & ~soft_off & ~fault_latched;
      los <= ~sig_s;
      data_ready <= link_ready & ana_s;
    end
  end
  assign link.laser_fault_flag = fault_latched;
  assign link.rx_signal_lost = los;
  assign link.dev_scl_out = 1'b0;
  assign link.dev_sda_out = 1'b0;

  // ----------------------------------------
  // two-wire slave
  // ----------------------------------------
  dev_state_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] txd;
  logic [7:0] ptr;
  logic [3:0] wr_count;
  logic [31:0] busy_cnt;
  logic [7:0] stretch_cnt;
  logic is_read;
  logic dev_sel;
  logic first;
  logic soft_pend;
  logic nack_seen;
  logic sda_oe;
  logic scl_oe;
  logic [7:0] mem [0:255];
  wire [7:0] ctrl_byte = {1'b0, soft_off, 3'b000, fault_latched, los, data_ready};
  wire ctrl_hit = dev_sel & (ptr == `CTRL_STATUS_OFS);
  wire [7:0] rd_byte = !dev_sel ? 8'h00 : (ctrl_hit ? ctrl_byte : mem[ptr]);
  wire addr_match = (shreg[7:1] == `DEV_ID_ADDR) | (shreg[7:1] == `DEV_DIAG_ADDR);
  wire addr_hit = addr_match & link_ready & (busy_cnt == '0);
  wire byte_end = scl_fall & (cnt == 4'h8);
  wire data_take = (state == D_WBYTE) & byte_end & ~first & (wr_count < `MAX_WR_BYTES);
  wire load_rd = scl_fall & (((state == D_ACK_ADDR) & is_read) | ((state == D_RACK) & ~nack_seen));
  // byte-level sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= D_IDLE;
      cnt <= '0;
      shreg <= '0;
      txd <= '0;
      ptr <= '0;
      wr_count <= '0;
      is_read <= 1'b0;
      dev_sel <= 1'b0;
      first <= 1'b0;
      soft_pend <= 1'b0;
      nack_seen <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state <= D_ADDR;
      cnt <= '0;
      sda_oe <= 1'b0;
      wr_count <= '0;
      soft_pend <= soft_off;
    end else if (stop_cond) begin
      state <= D_IDLE;
      sda_oe <= 1'b0;
    end else if (load_rd) begin
      txd <= {rd_byte[6:0], 1'b0};
      sda_oe <= ~rd_byte[7];
      cnt <= 4'h1;
      state <= D_RBYTE;
    end else begin
      case (state)
        D_ADDR, D_WBYTE: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_r};
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= '0;
            sda_oe <= 1'b1;
            state <= D_ACK_W;
            if (state == D_ADDR) begin
              is_read <= shreg[0];
              dev_sel <= shreg[1];
              first <= ~shreg[0];
              state <= D_ACK_ADDR;
              if (!addr_hit) begin
                sda_oe <= 1'b0;
                state <= D_IDLE;
              end
            end else if (first) begin
              ptr <= shreg;
              first <= 1'b0;
            end else if (data_take) begin
              ptr <= ptr + 8'h01;
              wr_count <= wr_count + 4'h1;
              if (ctrl_hit) begin
                soft_pend <= shreg[`SOFT_OFF_BIT];
              end
            end else begin
              sda_oe <= 1'b0; // ninth byte refused
              state <= D_IDLE;
            end
          end
        end
        D_ACK_ADDR, D_ACK_W: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= D_WBYTE;
          end
        end
        D_RBYTE: begin
          if (scl_fall && cnt == 4'h8) begin
            sda_oe <= 1'b0;
            cnt <= '0;
            ptr <= ptr + 8'h01;
            state <= D_RACK;
          end else if (scl_fall) begin
            sda_oe <= ~txd[7];
            txd <= {txd[6:0], 1'b0};
            cnt <= cnt + 4'h1;
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            nack_seen <= sda_r;
          end else if (scl_fall) begin
            state <= D_IDLE;
          end
        end
        default: state <= D_IDLE;
      endcase
    end
  end
  // array for the diagnostic page, control byte kept apart
  always_ff @(posedge core_clk) begin
    if (data_take && dev_sel && !ctrl_hit) begin
      mem[ptr] <= shreg;
    end
  end
  // soft-off applies and the write cycle starts at the stop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      soft_off <= 1'b0;
      busy_cnt <= '0;
    end else if (stop_cond && state != D_IDLE) begin
      soft_off <= soft_pend;
      if (wr_count > `HALF_WR_BYTES) begin
        busy_cnt <= WR8_CYC;
      end else if (wr_count != 4'h0) begin
        busy_cnt <= WR4_CYC;
      end
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - 32'h0000_0001;
    end
  end
  // holds the clock low while a read byte is fetched
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stretch_cnt <= '0;
      scl_oe <= 1'b0;
    end else if (load_rd && !start_cond && !stop_cond) begin
      stretch_cnt <= 8'(STRETCH_CYC);
      scl_oe <= (STRETCH_CYC != 0);
    end else if (stretch_cnt != '0) begin
      stretch_cnt <= stretch_cnt - 8'h01;
      scl_oe <= (stretch_cnt != 8'h01);
    end
  end
  assign link.dev_sda_oe = sda_oe;
  assign link.dev_scl_oe = scl_oe;
endmodule : optical_module_end

// ---- hdl/optical_defs.svh ----
// timing counts, register layout and bus addresses of the optical module link
`ifndef OPTICAL_DEFS_SVH
`define OPTICAL_DEFS_SVH
`define CLK_PERIOD_NS 10
`define T_INIT_MS 300
`define T_RESET_US 10
`define T_DIS_GAP_MS 10
`define T_BUF_US 20
`define T_WR4_MS 40
`define T_WR8_MS 80
`define SCL_MAX_KHZ 400
`define T_INIT_CYC ((`T_INIT_MS * 1000000) / `CLK_PERIOD_NS)
`define T_RESET_CYC ((`T_RESET_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_DIS_GAP_CYC ((`T_DIS_GAP_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_BUF_CYC ((`T_BUF_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WR4_CYC ((`T_WR4_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WR8_CYC ((`T_WR8_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCL_QTR_CYC (((1000000 / `SCL_MAX_KHZ) + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))
`define STRETCH_CYC 8
`define DEV_ID_ADDR 7'h50
`define DEV_DIAG_ADDR 7'h51
`define CTRL_STATUS_OFS 8'h6e
`define SOFT_OFF_BIT 6
`define FAULT_BIT 2
`define LOS_BIT 1
`define DREADY_BIT 0
`define MAX_WR_BYTES 4'h8
`define HALF_WR_BYTES 4'h4
`endif

// ---- hdl/optical_pkg.sv ----
// state types of both ends of the optical module link
package optical_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK_ADDR, D_WBYTE, D_ACK_W, D_RBYTE, D_RACK} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_STOP, H_GAP} host_state_t;
endpackage : optical_pkg

// ---- hdl/optical_link_if.sv ----
// pins between host board and optical module, with open-drain resolution
`timescale 1ns/10ps
interface optical_link_if;
  logic laser_off_request;
  logic laser_fault_flag;
  logic rx_signal_lost;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // pulled-up wires, low whenever an enabled driver pulls them down
  assign scl = (host_scl_oe ? host_scl_out : 1'b1) & (dev_scl_oe ? dev_scl_out : 1'b1);
  assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);
  modport module_end (input laser_off_request, scl, sda, output laser_fault_flag, rx_signal_lost,
    dev_scl_out, dev_scl_oe, dev_sda_out, dev_sda_oe);
  modport host_end (input laser_fault_flag, rx_signal_lost, scl, sda, output laser_off_request,
    host_scl_out, host_scl_oe, host_sda_out, host_sda_oe);
endinterface : optical_link_if

// ---- hdl/sync2.sv ----
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;
  if (WIDTH < 1) begin : g_bad
    $error("sync2 width must be at least one");
  end
  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : sync2

// ---- hdl/optical_host_end.sv ----
// host end: laser-off pin pacing, status pin sampling and two-wire master
`timescale 1ns/10ps
`include "optical_defs.svh"
module optical_host_end
  import optical_pkg::*;
#(
  parameter int unsigned GAP_CYC = `T_DIS_GAP_CYC,
  parameter int unsigned RESET_CYC = `T_RESET_CYC,
  parameter int unsigned BUF_CYC = `T_BUF_CYC,
  parameter int unsigned WR4_CYC = `T_WR4_CYC,
  parameter int unsigned WR8_CYC = `T_WR8_CYC,
  parameter int unsigned QTR_CYC = `SCL_QTR_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  optical_link_if.host_end link,
  input wire logic laser_off_in,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_dev,
  input wire logic [7:0] cmd_addr,
  input wire logic [3:0] cmd_len,
  input wire logic [63:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [63:0] rsp_rdata,
  output logic fault_seen,
  output logic los_seen
);
  if (QTR_CYC < `SCL_QTR_CYC || RESET_CYC < 1 || BUF_CYC < 1 || WR8_CYC < WR4_CYC) begin : g_bad
    $error("optical_host_end timing parameters out of range");
  end

  // ----------------------------------------
  // pins and laser-off pacing
  // ----------------------------------------
  logic [3:0] s;
  logic lor;
  logic [31:0] gap_cnt;
  logic [31:0] hi_cnt;
  sync2 #(.WIDTH(4)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din({link.scl, link.sda, link.laser_fault_flag, link.rx_signal_lost}),
    .dout(s)
  );
  wire scl_s = s[3];
  wire sda_s = s[2];
  wire lor_rise = laser_off_in & ~lor & (gap_cnt == '0);
  wire lor_fall = ~laser_off_in & lor & (hi_cnt >= RESET_CYC - 1);
  // pin held high long enough to reset a fault, rises spaced apart
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lor <= 1'b0;
      gap_cnt <= '0;
      hi_cnt <= '0;
    end else begin
      gap_cnt <= lor_rise ? GAP_CYC - 1 : (gap_cnt != '0 ? gap_cnt - 32'h0000_0001 : gap_cnt);
      hi_cnt <= lor_rise ? '0 : (lor && hi_cnt < RESET_CYC ? hi_cnt + 32'h0000_0001 : hi_cnt);
      lor <= lor_rise | (lor & ~lor_fall);
    end
  end
  // status pins to the user side
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fault_seen <= 1'b0;
      los_seen <= 1'b0;
    end else begin
      fault_seen <= s[1];
      los_seen <= s[0];
    end
  end
  assign link.laser_off_request = lor;
  assign link.host_scl_out = 1'b0;
  assign link.host_sda_out = 1'b0;

  // ----------------------------------------
  // two-wire master
  // ----------------------------------------
  host_state_t hs;
  logic [7:0] qcnt;
  logic [1:0] q;
  logic [3:0] bit_i;
  logic [3:0] byte_i;
  logic [3:0] nbytes;
  logic [3:0] len;
  logic [8:0] rx9;
  logic [31:0] wait_cnt;
  logic rd_phase;
  logic wr;
  logic dev;
  logic [7:0] addr;
  logic [63:0] wdata;
  logic scl_oe;
  logic sda_oe;
  wire tick = (qcnt == 8'(QTR_CYC - 1));
  wire step = tick & ~((q == 2'd2) & ~scl_s);
  wire [6:0] wsh = 7'({byte_i - 4'h2, 3'b000});
  wire [63:0] wshift = wdata >> wsh;
  wire [7:0] cur_tx = (byte_i == 4'h0) ? {(`DEV_ID_ADDR | {6'b000000, dev}), rd_phase} :
    ((byte_i == 4'h1 && !rd_phase) ? addr : wshift[7:0]);
  wire receiving = rd_phase & (byte_i != 4'h0);
  wire last_byte = (byte_i == nbytes - 4'h1);
  wire [5:0] rd_pos = {byte_i[2:0] - 3'h1, 3'b000};
  wire [3:0] len_eff = (cmd_len == 4'h0) ? 4'h1 : ((cmd_len > `MAX_WR_BYTES) ? `MAX_WR_BYTES : cmd_len);
  // quarter-bit divider
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      qcnt <= '0;
    end else begin
      qcnt <= tick ? 8'h00 : qcnt + 8'h01;
    end
  end
  // transaction and bit sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hs <= H_IDLE;
      q <= '0;
      bit_i <= '0;
      byte_i <= '0;
      nbytes <= '0;
      len <= '0;
      rx9 <= '0;
      wait_cnt <= '0;
      rd_phase <= 1'b0;
      wr <= 1'b0;
      dev <= 1'b0;
      addr <= '0;
      wdata <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (hs)
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            wr <= cmd_write;
            dev <= cmd_dev;
            addr <= cmd_addr;
            len <= len_eff;
            wdata <= cmd_wdata;
            rd_phase <= 1'b0;
            byte_i <= '0;
            nbytes <= cmd_write ? len_eff + 4'h2 : 4'h2;
            rsp_nack <= 1'b0;
            q <= '0;
            hs <= H_START;
          end
        end
        H_START: begin
          if (step) begin
            q <= q + 2'd1;
            sda_oe <= (q >= 2'd1) | sda_oe;
            if (q == 2'd3) begin
              scl_oe <= 1'b1;
              bit_i <= '0;
              hs <= H_BYTE;
            end
          end
        end
        H_BYTE: begin
          if (step) begin
            q <= q + 2'd1;
            case (q)
              2'd0: sda_oe <= (bit_i < 4'h8) ? (~receiving & ~cur_tx[3'(4'h7 - bit_i)]) : (receiving & ~last_byte);
              2'd1: scl_oe <= 1'b0;
              2'd2: rx9 <= {rx9[7:0], sda_s};
              default: begin
                scl_oe <= 1'b1;
                bit_i <= bit_i + 4'h1;
                if (bit_i == 4'h8) begin
                  bit_i <= '0;
                  byte_i <= byte_i + 4'h1;
                  if (receiving) begin
                    rsp_rdata[rd_pos +: 8] <= rx9[8:1];
                  end
                  if (!receiving && rx9[0]) begin
                    rsp_nack <= 1'b1;
                    hs <= H_STOP;
                  end else if (last_byte) begin
                    hs <= H_STOP;
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (step) begin
            q <= q + 2'd1;
            if (q == 2'd0) begin
              sda_oe <= 1'b1;
            end else if (q == 2'd1) begin
              scl_oe <= 1'b0;
            end else if (q == 2'd3) begin
              sda_oe <= 1'b0;
              hs <= H_GAP;
              if (wr && !rsp_nack) begin
                wait_cnt <= (len > `HALF_WR_BYTES) ? WR8_CYC : WR4_CYC;
              end else begin
                wait_cnt <= BUF_CYC;
              end
            end
          end
        end
        H_GAP: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 32'h0000_0001;
          end else if (!wr && !rd_phase && !rsp_nack) begin
            rd_phase <= 1'b1;
            byte_i <= '0;
            nbytes <= len + 4'h1;
            q <= '0;
            hs <= H_START;
          end else begin
            rsp_valid <= 1'b1;
            hs <= H_IDLE;
          end
        end
        default: hs <= H_IDLE;
      endcase
    end
  end
  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_oe = sda_oe;
endmodule : optical_host_end

// ---- verification/optical_link_checker.sv ----
// concurrent checks on the pins between host end and module end
`timescale 1ns/10ps
module optical_link_checker #(
  parameter int unsigned RESET_CYC = 20,
  parameter int unsigned BUF_CYC = 50,
  parameter int unsigned GAP_CYC = 500
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic laser_off_request,
  input wire logic laser_fault_flag,
  input wire logic rx_signal_lost,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic laser_fault_in,
  input wire logic signal_present_in,
  input wire logic laser_on
);
  int unsigned fault_wait;
  int unsigned los_wait;
  int unsigned clr_cnt;
  int unsigned idle_cnt;
  int unsigned scl_cnt;
  int unsigned pin_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // bus events and helper counters
  // ----------------------------------------
  sequence s_start;
    scl && $fell(sda);
  endsequence
  // waits, pulse length and spacing in cycles
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fault_wait <= 0;
      los_wait <= 0;
      clr_cnt <= 0;
      idle_cnt <= 65535;
      scl_cnt <= 1000;
      pin_cnt <= 65535;
    end else begin
      fault_wait <= (laser_fault_in && !laser_fault_flag) ? fault_wait + 1 : 0;
      los_wait <= (rx_signal_lost == signal_present_in) ? los_wait + 1 : 0;
      clr_cnt <= (laser_off_request && !laser_fault_in) ? clr_cnt + 1 : 0;
      idle_cnt <= (scl && $rose(sda)) ? 0 : idle_cnt + 1;
      scl_cnt <= $rose(scl) ? 0 : scl_cnt + 1;
      pin_cnt <= $rose(laser_off_request) ? 0 : pin_cnt + 1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_laser_off_fast: assert property ($rose(laser_off_request) |-> ##[1:1000] !laser_on)
    else $error("laser still on after pin rise");
  chk_fault_flag_fast: assert property (fault_wait < 100000)
    else $error("fault flag late");
  chk_los_pin_follow: assert property (los_wait < 10000)
    else $error("signal lost pin late");
  chk_fault_clear: assert property (clr_cnt >= RESET_CYC + 8 |-> !laser_fault_flag)
    else $error("fault flag not cleared by pulse");
  chk_stretch_bound: assert property ($rose(dev_scl_oe) |-> ##[1:16] !dev_scl_oe)
    else $error("clock stretch too long");
  chk_sda_on_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("module data changed while clock high");
  chk_bus_idle_gap: assert property (s_start |-> idle_cnt >= BUF_CYC - 1)
    else $error("start too soon after stop");
  chk_scl_rate: assert property ($rose(scl) |-> scl_cnt >= 249)
    else $error("bus clock too fast");
  chk_pin_gap: assert property ($rose(laser_off_request) |-> pin_cnt >= GAP_CYC - 1)
    else $error("laser off pin raised too soon");
endmodule : optical_link_checker

// ---- verification/optical_module_control_status_tb_top.sv ----
// self-checking bench joining host end and module end of the optical link
`timescale 1ns/10ps
module optical_module_control_status_tb_top;
  logic core_clk, nrst, laser_off_in, cmd_valid, cmd_write, cmd_dev;
  logic [7:0] cmd_addr, a;
  logic [3:0] cmd_len, n;
  logic [63:0] cmd_wdata, rsp_rdata, m, wd;
  logic cmd_ready, rsp_valid, rsp_nack, fault_seen, los_seen, laser_on, link_ready;
  logic laser_fault_in, signal_present_in, analog_ok_in, dv = 1'b1;
  int n_fail, samples_checked, cyc, seed, k;
  optical_link_if link_if();
  localparam int unsigned RST = 20, WR4 = 300, WR8 = 600;
  optical_module_end #(.INIT_CYC(200), .RESET_CYC(RST), .WR4_CYC(WR4), .WR8_CYC(WR8))
    optical_module_end_inst (.core_clk(core_clk), .nrst(nrst), .link(link_if), .laser_fault_in(laser_fault_in),
    .signal_present_in(signal_present_in), .analog_ok_in(analog_ok_in), .laser_on(laser_on),
    .link_ready(link_ready));
  optical_host_end #(.GAP_CYC(500), .RESET_CYC(RST), .BUF_CYC(50), .WR4_CYC(WR4), .WR8_CYC(WR8))
    optical_host_end_inst (.core_clk(core_clk), .nrst(nrst), .link(link_if), .laser_off_in(laser_off_in),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
    .rsp_rdata(rsp_rdata), .fault_seen(fault_seen), .los_seen(los_seen));
  optical_link_checker #(.RESET_CYC(RST)) optical_link_checker_inst (
    .core_clk(core_clk), .nrst(nrst), .laser_off_request(link_if.laser_off_request),
    .laser_fault_flag(link_if.laser_fault_flag), .rx_signal_lost(link_if.rx_signal_lost),
    .dev_scl_oe(link_if.dev_scl_oe), .dev_sda_oe(link_if.dev_sda_oe), .scl(link_if.scl), .sda(link_if.sda),
    .laser_fault_in(laser_fault_in), .signal_present_in(signal_present_in), .laser_on(laser_on));
  // ----------------------------------------
  // clock, timeout, expectations and tasks
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      end_of_test();
    end
  end
  // status byte from soft-off, fault, lost and ready bits
  function automatic logic [63:0] exp_status(input logic [3:0] v);
    return {57'h0, v[3], 3'h0, v[2:0]};
  endfunction : exp_status
  function automatic logic [63:0] byte_mask(input logic [3:0] c);
    return (c >= 4'h8) ? ~64'h0 : ((64'h1 << (8 * c)) - 64'h1);
  endfunction : byte_mask
  task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t data %h expected %h", $time, got, exp);
    end
  endtask : cmp_data
  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  // one bus command: hold until taken, then wait for the response pulse
  task automatic do_cmd(input logic w, input logic [7:0] ad, input logic [3:0] c, input logic [63:0] d);
    @(posedge core_clk);
    cmd_write <= w;
    cmd_dev <= dv;
    cmd_addr <= ad;
    cmd_len <= c;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    do @(negedge core_clk); while (cmd_ready !== 1'b1);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    do @(negedge core_clk); while (rsp_valid !== 1'b1);
  endtask : do_cmd
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 98844;
    nrst = 1'b0;
    laser_off_in = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_dev = 1'b0;
    cmd_addr = 8'h00;
    cmd_len = 4'h0;
    cmd_wdata = 64'h0;
    laser_fault_in = 1'b0;
    signal_present_in = 1'b1;
    analog_ok_in = 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    k = 0;
    while (link_ready !== 1'b1 && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    cmp_bit(link_ready, 1'b1);
    repeat (3) @(negedge core_clk);
    cmp_bit(laser_on, 1'b1);
    // monitoring not yet working: ready bit low
    do_cmd(1'b0, 8'h6e, 4'h1, 64'h0);
    cmp_bit(rsp_nack, 1'b0);
    cmp_data(rsp_rdata & 64'hff, exp_status(4'h0));
    // light lost and laser fault together
    @(posedge core_clk);
    analog_ok_in <= 1'b1;
    laser_fault_in <= 1'b1;
    signal_present_in <= 1'b0;
    repeat (20) @(negedge core_clk);
    cmp_bit(fault_seen, 1'b1);
    cmp_bit(los_seen, 1'b1);
    do_cmd(1'b0, 8'h6e, 4'h1, 64'h0);
    cmp_data(rsp_rdata & 64'hff, exp_status(4'h7));
    @(posedge core_clk);
    laser_fault_in <= 1'b0;
    signal_present_in <= 1'b1;
    repeat (20) @(negedge core_clk);
    cmp_bit(los_seen, 1'b0);
    cmp_bit(fault_seen, 1'b1);
    // laser-off pulse clears the latched fault
    @(posedge core_clk);
    laser_off_in <= 1'b1;
    repeat (40) @(negedge core_clk);
    cmp_bit(laser_on, 1'b0);
    @(posedge core_clk);
    laser_off_in <= 1'b0;
    repeat (20) @(negedge core_clk);
    cmp_bit(fault_seen, 1'b0);
    cmp_bit(laser_on, 1'b1);
    // soft laser-off through the status byte
    do_cmd(1'b1, 8'h6e, 4'h1, 64'h40);
    cmp_bit(laser_on, 1'b0);
    do_cmd(1'b0, 8'h6e, 4'h1, 64'h0);
    cmp_data(rsp_rdata & 64'hff, exp_status(4'h9));
    do_cmd(1'b1, 8'h6e, 4'h1, 64'h0);
    cmp_bit(laser_on, 1'b1);
    // random short write, then read back once the write cycle ends
    n = 4'h1 + {2'b00, 2'($random(seed))};
    a = {2'b10, 6'($random(seed))};
    wd = {$random(seed), $random(seed)};
    m = byte_mask(n);
    do_cmd(1'b1, a, n, wd);
    cmp_bit(rsp_nack, 1'b0);
    do_cmd(1'b0, a, n, 64'h0);
    cmp_bit(rsp_nack, 1'b0);
    cmp_data(rsp_rdata & m, wd & m);
    dv = 1'b0;
    do_cmd(1'b0, a, n, 64'h0);
    cmp_data(rsp_rdata & m, 64'h0);
    // laser-off pin with the laser running
    @(posedge core_clk);
    laser_off_in <= 1'b1;
    repeat (9) @(negedge core_clk);
    cmp_bit(laser_on, 1'b0);
    end_of_test();
  end
endmodule : optical_module_control_status_tb_top
